// *** core/sef_stat_export.sv ***
// sef_stat_export.sv: statistics record framer, two transmit ports
// assumes sef_pkg compiled first and sef_defs.svh on the include path
//
// Summary of operation
// [RULE1] records pushed as events occur, never polled
// [RULE2] one ingress plus one egress record per clock
// [RULE3] one global reporting option at a time
// [RULE4] queue-size mode: record per enqueue and dequeue
// [RULE5] billing mode: ingress receive, egress transmit records
// [RULE6] enqueue/dequeue mode: tagged record per event
// [RULE7] single port carries ingress and egress records
// [RULE8] ingress and egress record sizes set separately
// [RULE9] dual ports: one ingress, one egress only
// [RULE10] records sent on transmit direction only
// [RULE11] preamble, ethernet FCS, 12 byte average gap
// [RULE12] far end should connect its return direction; the sink model drives no return path
// [RULE13] records of one direction never reordered
`timescale 1ns/10ps
`include "sef_defs.svh"

// ----------------------------------------
// one framing port, lane 0 ingress, lane 1 egress
// ----------------------------------------
module sef_port
  import sef_pkg::*;
#(
  parameter int MAX_WORDS = 8
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // records in
  input  wire logic [1:0]  inValid,
  input  wire logic [63:0] inData0,
  input  wire logic [63:0] inData1,
  input  wire logic [3:0]  inBytes0,
  input  wire logic [3:0]  inBytes1,
  // transmit word stream
  output sef_word_e        txKind,
  output logic [127:0]     txData,
  output logic [1:0]       txLaneValid,
  output logic [3:0]       txBytes0,
  output logic [3:0]       txBytes1,
  output logic [1:0]       dropPulse
);
  typedef enum {ST_IDLE, ST_PRE, ST_DATA, ST_FCS, ST_GAP} sef_state_e;
  localparam int GAP_SHORT = `SEF_IPG_BYTES / `SEF_WORD_BYTES;
  localparam int GAP_LONG  = (`SEF_IPG_BYTES + `SEF_WORD_BYTES - 1) / `SEF_WORD_BYTES;
  localparam int CW        = $clog2(MAX_WORDS + 1);

  sef_state_e    state_q;
  logic [1:0]    holdV_q;
  logic [63:0]   holdD_q [2];
  logic [3:0]    holdB_q [2];
  logic [CW-1:0] wordCnt_q;
  logic [1:0]    gapLeft_q;
  logic          gapLong_q;
  logic [31:0]   crc_q;
  sef_word_e     txKind_q;
  logic [127:0]  txData_q;
  logic [1:0]    txLaneValid_q;
  logic [3:0]    txBytes_q [2];
  logic [1:0]    drop_q;
  logic          emit;
  logic          anyPend;
  logic [1:0]    outV;
  logic [1:0]    pendNext;
  logic [63:0]   inD [2];
  logic [3:0]    inB [2];
  logic [63:0]   outD [2];
  logic [3:0]    outB [2];

  // ethernet crc over the low n bytes of a word
  function automatic logic [31:0] crcBytes(input logic [31:0] c, input logic [63:0] d,
                                           input logic [3:0] n);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < n) begin
        for (int b = 0; b < 8; b++) begin
          r = (r[0] ^ d[8*i+b]) ? ((r >> 1) ^ `SEF_CRC_POLY) : (r >> 1);
        end
      end
    end
    return r;
  endfunction

  assign inD[0] = inData0;
  assign inD[1] = inData1;
  assign inB[0] = inBytes0;
  assign inB[1] = inBytes1;

  // ----------------------------------------
  // lane selection
  // ----------------------------------------
  always_comb begin
    emit    = (state_q == ST_DATA);
    anyPend = |(holdV_q | inValid);
    for (int l = 0; l < 2; l++) begin
      outV[l] = emit & (holdV_q[l] | inValid[l]);                         // [RULE2]
      outD[l] = holdV_q[l] ? holdD_q[l] : inD[l];                         // [RULE13]
      outB[l] = holdV_q[l] ? holdB_q[l] : inB[l];
      pendNext[l] = holdV_q[l] ? (emit ? inValid[l] : 1'b1)
                               : (emit ? 1'b0 : inValid[l]);
    end
  end

  // ----------------------------------------
  // one-record hold per lane
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      holdV_q    <= 2'h0;
      holdD_q[0] <= 64'h0;
      holdD_q[1] <= 64'h0;
      holdB_q[0] <= 4'h0;
      holdB_q[1] <= 4'h0;
      drop_q     <= 2'h0;
    end else begin
      holdV_q <= pendNext;
      for (int l = 0; l < 2; l++) begin
        if (inValid[l] && (emit ? holdV_q[l] : !holdV_q[l])) begin          // [RULE13]
          holdD_q[l] <= inD[l];
          holdB_q[l] <= inB[l];
        end
        drop_q[l] <= !emit & holdV_q[l] & inValid[l];
      end
    end
  end

  // ----------------------------------------
  // framing state machine
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q   <= ST_IDLE;
      wordCnt_q <= '0;
      gapLeft_q <= 2'h0;
      gapLong_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (anyPend) begin                                                // [RULE1]
            state_q <= ST_PRE;
          end
        end
        ST_PRE: begin
          state_q   <= ST_DATA;
          wordCnt_q <= '0;
        end
        ST_DATA: begin
          wordCnt_q <= wordCnt_q + CW'(1);
          if (wordCnt_q == CW'(MAX_WORDS - 1) || pendNext == 2'h0) begin
            state_q <= ST_FCS;
          end
        end
        ST_FCS: begin
          state_q   <= ST_GAP;
          gapLeft_q <= gapLong_q ? 2'(GAP_LONG) : 2'(GAP_SHORT);            // [RULE11]
          gapLong_q <= ~gapLong_q;
        end
        ST_GAP: begin
          gapLeft_q <= gapLeft_q - 2'h1;
          if (gapLeft_q == 2'h1) begin
            state_q <= anyPend ? ST_PRE : ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // frame check sequence
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      crc_q <= `SEF_CRC_INIT;
    end else if (state_q == ST_PRE) begin
      crc_q <= `SEF_CRC_INIT;
    end else if (emit) begin
      crc_q <= crcBytes(crcBytes(crc_q, outD[0], outV[0] ? outB[0] : 4'h0),
                        outD[1], outV[1] ? outB[1] : 4'h0);                 // [RULE11]
    end
  end

  // ----------------------------------------
  // transmit word register
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txKind_q      <= W_IDLE;
      txData_q      <= 128'h0;
      txLaneValid_q <= 2'h0;
      txBytes_q[0]  <= 4'h0;
      txBytes_q[1]  <= 4'h0;
    end else begin
      txKind_q      <= W_IDLE;
      txData_q      <= 128'h0;
      txLaneValid_q <= 2'h0;
      txBytes_q[0]  <= 4'h0;
      txBytes_q[1]  <= 4'h0;
      case (state_q)
        ST_PRE: begin
          txKind_q     <= W_PRE;
          txData_q     <= {64'h0, `SEF_PREAMBLE};                           // [RULE11]
          txBytes_q[0] <= `SEF_MAX_BYTES;
        end
        ST_DATA: begin
          txKind_q      <= W_DATA;
          txData_q      <= {outD[1], outD[0]};                              // [RULE7]
          txLaneValid_q <= outV;
          txBytes_q[0]  <= outV[0] ? outB[0] : 4'h0;                        // [RULE8]
          txBytes_q[1]  <= outV[1] ? outB[1] : 4'h0;
        end
        ST_FCS: begin
          txKind_q     <= W_FCS;
          txData_q     <= {96'h0, ~crc_q};                                  // [RULE11]
          txBytes_q[0] <= `SEF_FCS_BYTES;
        end
        default: txKind_q <= W_IDLE;
      endcase
    end
  end

  assign txKind      = txKind_q;
  assign txData      = txData_q;
  assign txLaneValid = txLaneValid_q;
  assign txBytes0    = txBytes_q[0];
  assign txBytes1    = txBytes_q[1];
  assign dropPulse   = drop_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_pre_first: assert property ( // [RULE11]
    txKind_q == W_DATA && $past(txKind_q) != W_DATA |-> $past(txKind_q) == W_PRE)
    else $error("data word without preamble");
  a_fcs_gap: assert property ( // [RULE11]
    txKind_q == W_FCS |-> $past(txKind_q) == W_DATA ##1 txKind_q == W_IDLE)
    else $error("fcs not between data and gap");
  a_fcs_value: assert property ( // [RULE11]
    state_q == ST_FCS |=> txData_q[31:0] == ~$past(crc_q))
    else $error("fcs word wrong");
  a_rec_rate: assert property ( // [RULE2]
    emit && !holdV_q[0] && inValid[0] |=> txLaneValid_q[0] && txData_q[63:0] == $past(inData0))
    else $error("ingress record not sent at once");
  a_lane_order: assert property ( // [RULE13]
    emit && holdV_q[1] && inValid[1]
    |=> txData_q[127:64] == $past(holdD_q[1]) && holdD_q[1] == $past(inData1))
    else $error("egress records reordered");
  a_push_bound: assert property ( // [RULE1]
    inValid[0] && !holdV_q[0] && !emit |-> ##[1:8] txLaneValid_q[0])
    else $error("held record not pushed out");

  c_full_packet: cover property (state_q == ST_DATA && wordCnt_q == CW'(MAX_WORDS - 1));
  c_both_lanes:  cover property (txLaneValid_q == 2'h3);
  c_drop:        cover property (drop_q != 2'h0);
endmodule

// ----------------------------------------
// top: record building and port routing
// ----------------------------------------
module sef_stat_export
  import sef_pkg::*;
#(
  parameter int MAX_WORDS = 8
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // configuration
  input  sef_opt_e         reportOpt,
  input  wire logic        dualMode,
  input  wire logic [3:0]  ingRecBytes,
  input  wire logic [3:0]  egrRecBytes,
  // ingress events
  input  wire logic        ingEvtValid,
  input  sef_evt_e         ingEvtKind,
  input  wire logic [31:0] ingEvtTag,
  input  wire logic [23:0] ingEvtQsize,
  // egress events
  input  wire logic        egrEvtValid,
  input  wire logic [31:0] egrEvtTag,
  // port 0 transmit
  output sef_word_e        tx0Kind,
  output logic [127:0]     tx0Data,
  output logic [1:0]       tx0LaneValid,
  output logic [3:0]       tx0Bytes0,
  output logic [3:0]       tx0Bytes1,
  // port 1 transmit
  output sef_word_e        tx1Kind,
  output logic [127:0]     tx1Data,
  output logic [1:0]       tx1LaneValid,
  output logic [3:0]       tx1Bytes0,
  output logic [3:0]       tx1Bytes1,
  // status
  output logic             ingDrop,
  output logic             egrDrop
);
  logic        ingV;
  logic        egrV;
  logic        queueEvt;
  logic [63:0] ingD;
  logic [63:0] egrD;
  logic [3:0]  ingB;
  logic [3:0]  egrB;
  logic [1:0]  p0V;
  logic [1:0]  p1V;
  logic [1:0]  drop0;
  logic [1:0]  drop1;

  // record size, zero or oversize means full word
  function automatic logic [3:0] recSize(input logic [3:0] n);
    return (n == 4'h0 || n > `SEF_MAX_BYTES) ? `SEF_MAX_BYTES : n;
  endfunction

  // clear bytes beyond the record size
  function automatic logic [63:0] trimRec(input logic [63:0] d, input logic [3:0] n);
    logic [63:0] m;
    m = d;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) >= recSize(n)) begin
        m[8*i +: 8] = 8'h00;
      end
    end
    return m;
  endfunction

  // ----------------------------------------
  // record selection by reporting option
  // ----------------------------------------
  always_comb begin
    queueEvt = (ingEvtKind == EVT_ENQ) || (ingEvtKind == EVT_DEQ);
    case (reportOpt)                                                        // [RULE3]
      OPT_QSIZE:  ingV = ingEvtValid & queueEvt;                            // [RULE4]
      OPT_BILL:   ingV = ingEvtValid & (ingEvtKind == EVT_RX);              // [RULE5]
      OPT_ENQDEQ: ingV = ingEvtValid & queueEvt;                            // [RULE6]
      default:    ingV = 1'b0;
    endcase
    egrV = egrEvtValid & (reportOpt == OPT_BILL);                           // [RULE5]
    ingD = trimRec({6'h00, ingEvtKind,
                    (reportOpt == OPT_QSIZE) ? ingEvtQsize : 24'h000000,    // [RULE4]
                    ingEvtTag}, ingRecBytes);                               // [RULE8]
    egrD = trimRec({6'h00, 2'h3, 24'h000000, egrEvtTag}, egrRecBytes);
    ingB = recSize(ingRecBytes);
    egrB = recSize(egrRecBytes);
    p0V  = {egrV & !dualMode, ingV};                                        // [RULE7]
    p1V  = {egrV & dualMode, 1'b0};                                         // [RULE9]
  end

  // ----------------------------------------
  // ports, transmit only
  // ----------------------------------------
  sef_port #(.MAX_WORDS(MAX_WORDS)) port0 (                                 // [RULE10]
    .clk         (clk),
    .resetn      (resetn),
    .inValid     (p0V),
    .inData0     (ingD),
    .inData1     (egrD),
    .inBytes0    (ingB),
    .inBytes1    (egrB),
    .txKind      (tx0Kind),
    .txData      (tx0Data),
    .txLaneValid (tx0LaneValid),
    .txBytes0    (tx0Bytes0),
    .txBytes1    (tx0Bytes1),
    .dropPulse   (drop0)
  );

  sef_port #(.MAX_WORDS(MAX_WORDS)) port1 (
    .clk         (clk),
    .resetn      (resetn),
    .inValid     (p1V),
    .inData0     (ingD),
    .inData1     (egrD),
    .inBytes0    (ingB),
    .inBytes1    (egrB),
    .txKind      (tx1Kind),
    .txData      (tx1Data),
    .txLaneValid (tx1LaneValid),
    .txBytes0    (tx1Bytes0),
    .txBytes1    (tx1Bytes1),
    .dropPulse   (drop1)
  );

  assign ingDrop = drop0[0];
  assign egrDrop = drop0[1] | drop1[1];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_opt_excl: assert property ( // [RULE3]
    ingV |-> (reportOpt == OPT_BILL) == (ingEvtKind == EVT_RX))
    else $error("ingress record of wrong option");
  a_qsize_rec: assert property ( // [RULE4]
    reportOpt == OPT_QSIZE && ingEvtValid && queueEvt && ingRecBytes == 4'h8
    |-> ingV && ingD[55:32] == ingEvtQsize)
    else $error("queue size record missing");
  a_bill_egr: assert property ( // [RULE5]
    egrV == (egrEvtValid && reportOpt == OPT_BILL))
    else $error("egress billing record wrong");
  a_enqdeq_rec: assert property ( // [RULE6]
    reportOpt == OPT_ENQDEQ && ingEvtValid && queueEvt |-> ingV && ingD[55:32] == 24'h0)
    else $error("enqueue dequeue record wrong");
  a_single_lane: assert property ( // [RULE7]
    !dualMode |-> tx1LaneValid == 2'h0 && p1V == 2'h0)
    else $error("single mode used second port");
  a_size_trim: assert property ( // [RULE8]
    ingV && ingRecBytes == 4'h4 |-> ingD[63:32] == 32'h0)
    else $error("ingress record not trimmed");
  a_dual_split: assert property ( // [RULE9]
    dualMode |-> (!p0V[1] && !p1V[0]) ##1 !tx0LaneValid[1])
    else $error("dual mode lanes mixed");

  c_dual_egr: cover property (dualMode && tx1LaneValid[1]);
  c_qsize:    cover property (reportOpt == OPT_QSIZE && ingV);
endmodule

// *** core/sef_defs.svh ***
// sef_defs.svh: framing constants of the statistics export framer
// assumes inclusion by bare name from core/
`ifndef SEF_DEFS_SVH
`define SEF_DEFS_SVH
`define SEF_PREAMBLE   64'hd555555555555555
`define SEF_CRC_INIT   32'hffffffff
`define SEF_CRC_POLY   32'hedb88320
`define SEF_IPG_BYTES  12
`define SEF_WORD_BYTES 8
`define SEF_FCS_BYTES  4'h4
`define SEF_MAX_BYTES  4'h8
`endif

// *** core/sef_pkg.sv ***
// sef_pkg.sv: types of the statistics export framer
// assumes nothing beyond a SystemVerilog compiler
package sef_pkg;
  typedef enum logic [1:0] {OPT_QSIZE, OPT_BILL, OPT_ENQDEQ} sef_opt_e;
  typedef enum logic [1:0] {EVT_ENQ, EVT_DEQ, EVT_RX} sef_evt_e;
  typedef enum logic [1:0] {W_IDLE, W_PRE, W_DATA, W_FCS} sef_word_e;
endpackage

// *** sim/sef_stat_sink.sv ***
// sef_stat_sink.sv: model of the far statistics processor on one port
// assumes sef_pkg compiled first and sef_defs.svh on the include path
`timescale 1ns/10ps
`include "sef_defs.svh"
// ----------------------------------------
// frame checker of one transmit stream
// ----------------------------------------
module sef_stat_sink
  import sef_pkg::*;
#(
  parameter int MAX_WORDS = 8
)
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // transmit stream watched
  input  sef_word_e         txKind,
  input  wire logic [127:0] txData,
  input  wire logic [1:0]   txLaneValid,
  input  wire logic [3:0]   txBytes0,
  input  wire logic [3:0]   txBytes1,
  // framing faults seen
  output int                errCount
);
  // listens only, drives no return path
  sef_word_e   prevKind;
  logic [31:0] crc;
  int          words;
  int          gap;
  int          prevGap;
  initial errCount = 0;
  function automatic logic [31:0] crcAdd(logic [31:0] c, logic [63:0] d, logic [3:0] n);
    for (int b = 0; b < 8; b++) begin
      if (b < n) begin
        c = c ^ {24'h0, d[8*b +: 8]};
        for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ `SEF_CRC_POLY : c >> 1;
      end
    end
    return c;
  endfunction
  task automatic chk(string what, logic [63:0] e, logic [63:0] s);
    if (e !== s) begin
      $display("Error %s expected %h seen %h", what, e, s);
      errCount++;
    end
  endtask
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prevKind <= W_IDLE;
      gap <= 2;
      prevGap <= 2;
    end else begin
      prevKind <= txKind;
      case (txKind)
        W_PRE: begin
          chk("preamble", `SEF_PREAMBLE, txData[63:0]);
          chk("preamble bytes", {60'h0, `SEF_MAX_BYTES}, {60'h0, txBytes0});
          chk("gap short", 64'h0,
              {63'h0, prevKind != W_IDLE || (gap == 1 && prevGap == 1)});
          prevGap <= gap;
          crc <= `SEF_CRC_INIT;
          words <= 0;
        end
        W_DATA: begin
          chk("data order", 64'h1,
              {63'h0, prevKind inside {W_PRE, W_DATA} && words < MAX_WORDS});
          crc <= crcAdd(crcAdd(crc, txData[63:0], txLaneValid[0] ? txBytes0 : 4'h0),
                        txData[127:64], txLaneValid[1] ? txBytes1 : 4'h0);
          words <= words + 1;
        end
        W_FCS: begin
          chk("fcs order", 64'h1, {63'h0, prevKind == W_DATA});
          chk("fcs", {32'h0, ~crc}, {32'h0, txData[31:0]});
          chk("fcs bytes", {60'h0, `SEF_FCS_BYTES}, {60'h0, txBytes0});
        end
        default: gap <= (prevKind == W_FCS) ? 1 : gap + 1;
      endcase
    end
  end
endmodule

// *** sim/statistics_export_framer_tb_top.sv ***
// statistics_export_framer_tb_top.sv: self-checking bench of the framer
// assumes sef_pkg, sef_stat_export and sef_stat_sink compiled first
`timescale 1ns/10ps
module statistics_export_framer_tb_top;
  import sef_pkg::*;
  localparam int WORDS = 2;
  localparam int LIMIT = 6000;
  logic         clk, resetn, dualMode, ingEvtValid, egrEvtValid, ingDrop, egrDrop;
  sef_opt_e     reportOpt;
  sef_evt_e     ingEvtKind;
  sef_word_e    tx0Kind, tx1Kind;
  logic [3:0]   ingRecBytes, egrRecBytes, tx0Bytes0, tx0Bytes1, tx1Bytes0, tx1Bytes1;
  logic [31:0]  ingEvtTag, egrEvtTag;
  logic [23:0]  ingEvtQsize;
  logic [127:0] tx0Data, tx1Data;
  logic [1:0]   tx0LaneValid, tx1LaneValid;
  int           errCount0, errCount1, failCount = 0, testsRun = 0, cycles = 0;
  integer       seed;
  logic         ingLast, egrLast;
  logic [67:0]  ingQ[$], egrQ[$];
  // ----------------------------------------
  // design, far-end models, clock
  // ----------------------------------------
  sef_stat_export #(.MAX_WORDS(WORDS)) sef_stat_export_inst (.clk, .resetn, .reportOpt,
    .dualMode, .ingRecBytes, .egrRecBytes, .ingEvtValid, .ingEvtKind, .ingEvtTag, .ingEvtQsize,
    .egrEvtValid, .egrEvtTag, .tx0Kind, .tx0Data, .tx0LaneValid, .tx0Bytes0, .tx0Bytes1,
    .tx1Kind, .tx1Data, .tx1LaneValid, .tx1Bytes0, .tx1Bytes1, .ingDrop, .egrDrop);
  sef_stat_sink #(.MAX_WORDS(WORDS)) sef_stat_sink_inst (.clk, .resetn, .txKind(tx0Kind),
    .txData(tx0Data), .txLaneValid(tx0LaneValid), .txBytes0(tx0Bytes0), .txBytes1(tx0Bytes1),
    .errCount(errCount0));
  sef_stat_sink #(.MAX_WORDS(WORDS)) sef_stat_sink_inst1 (.clk, .resetn, .txKind(tx1Kind),
    .txData(tx1Data), .txLaneValid(tx1LaneValid), .txBytes0(tx1Bytes0), .txBytes1(tx1Bytes1),
    .errCount(errCount1));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic printVerdict;
    $display("checks %0d mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failCount++;
      $display("Error timeout expected below %0d seen %0d", LIMIT, cycles);
      printVerdict();
    end
  end
  task automatic chk(string what, logic [67:0] e, logic [67:0] s);
    testsRun++;
    if (e !== s) begin
      failCount++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask
  function automatic logic [67:0] mkRec(logic [1:0] k, logic [23:0] q, logic [31:0] t,
                                        logic [3:0] sz);
    logic [63:0] r;
    logic [3:0]  n;
    n = (sz == 4'h0 || sz > 4'h8) ? 4'h8 : sz;
    r = {6'h0, k, q, t};
    for (int b = 0; b < 8; b++) if (b >= n) r[8*b +: 8] = 8'h00;
    return {n, r};
  endfunction
  task automatic take(string what, ref logic [67:0] q[$], input logic [3:0] n, logic [63:0] d);
    if (q.size() == 0) chk(what, 68'h0, {n, d});
    else chk(what, q.pop_front(), {n, d});
  endtask
  // one cycle: look at outputs, then drive events
  task automatic step(logic iv, sef_evt_e k, logic [31:0] t, logic [23:0] q, logic ev,
                      logic [31:0] et);
    logic ip;
    logic ep;
    @(negedge clk);
    if (ingDrop === 1'b1) chk("ingress drop cause", 68'h1, {67'h0, ingLast});
    if (egrDrop === 1'b1) chk("egress drop cause", 68'h1, {67'h0, egrLast});
    if (ingDrop === 1'b1 && ingQ.size() > 0) void'(ingQ.pop_back());
    if (egrDrop === 1'b1 && egrQ.size() > 0) void'(egrQ.pop_back());
    if (tx0Kind === W_DATA && tx0LaneValid[0] === 1'b1) begin
      take("ingress record", ingQ, tx0Bytes0, tx0Data[63:0]);
    end
    if (tx0Kind === W_DATA && tx0LaneValid[1] === 1'b1) begin
      if (dualMode) chk("port0 egress lane", 68'h0, 68'h1);
      else take("egress record", egrQ, tx0Bytes1, tx0Data[127:64]);
    end
    if (!dualMode) chk("port1 idle", {66'h0, W_IDLE}, {66'h0, tx1Kind});
    else if (tx1Kind === W_DATA) begin
      if (tx1LaneValid[0] !== 1'b0) chk("port1 ingress lane", 68'h0, 68'h1);
      if (tx1LaneValid[1] === 1'b1) begin
        take("egress record", egrQ, tx1Bytes1, tx1Data[127:64]);
      end
    end
    ingEvtValid = iv;
    ingEvtKind = k;
    ingEvtTag = t;
    ingEvtQsize = q;
    egrEvtValid = ev;
    egrEvtTag = et;
    ip = iv && ((reportOpt == OPT_BILL) == (k == EVT_RX));
    ep = ev && reportOpt == OPT_BILL;
    if (ip) begin
      ingQ.push_back(mkRec(k, reportOpt == OPT_QSIZE ? q : 24'h0, t, ingRecBytes));
    end
    if (ep) egrQ.push_back(mkRec(2'h3, 24'h0, et, egrRecBytes));
    ingLast = ip;
    egrLast = ep;
  endtask
  task automatic idle(int n);
    repeat (n) step(1'b0, EVT_ENQ, 32'h0, 24'h0, 1'b0, 32'h0);
  endtask
  // one configuration: lone event from idle, then random traffic
  task automatic run(sef_opt_e o, logic dm, logic [3:0] ib, logic [3:0] eb, int n);
    logic [31:0] r;
    idle(12);
    reportOpt = o;
    dualMode = dm;
    ingRecBytes = ib;
    egrRecBytes = eb;
    idle(4);
    step(1'b1, o == OPT_BILL ? EVT_RX : EVT_DEQ, 32'h5a5a0001, 24'hfffffe, 1'b0, 32'h0);
    idle(2);
    chk("kind after two edges", {66'h0, W_PRE}, {66'h0, tx0Kind});
    idle(1);
    chk("kind after three edges", {66'h0, W_DATA}, {66'h0, tx0Kind});
    repeat (n) begin
      r = $random(seed);
      step(r[0] | r[1], r[3:2] == 2'h3 ? EVT_ENQ : sef_evt_e'(r[3:2]), $random(seed), r[31:8],
           r[4] | r[5], $random(seed));
    end
    idle(30);
    chk("ingress records left", 68'h0, {36'h0, ingQ.size()});
    chk("egress records left", 68'h0, {36'h0, egrQ.size()});
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'hde39;
    ingLast = 1'b0;
    egrLast = 1'b0;
    resetn = 1'b0;
    reportOpt = OPT_QSIZE;
    dualMode = 1'b0;
    ingRecBytes = 4'h8;
    egrRecBytes = 4'h8;
    ingEvtValid = 1'b0;
    ingEvtKind = EVT_ENQ;
    ingEvtTag = 32'h0;
    ingEvtQsize = 24'h0;
    egrEvtValid = 1'b0;
    egrEvtTag = 32'h0;
    repeat (6) @(negedge clk);
    chk("kind in reset", {66'h0, W_IDLE}, {66'h0, tx0Kind});
    resetn = 1'b1;
    run(OPT_QSIZE, 1'b0, 4'h1, 4'h8, 300);
    run(OPT_BILL, 1'b0, 4'h9, 4'h3, 300);
    run(OPT_ENQDEQ, 1'b0, 4'h0, 4'h5, 300);
    run(OPT_BILL, 1'b1, 4'h7, 4'hf, 300);
    run(OPT_QSIZE, 1'b1, 4'h8, 4'h6, 200);
    run(OPT_ENQDEQ, 1'b1, 4'h4, 4'h1, 200);
    chk("framing faults", 68'h0, {36'h0, errCount0 + errCount1});
    printVerdict();
  end
endmodule
